// ### inc/arc_pkg.sv
package arc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS  = 8'h01;
    localparam logic [7:0] ADDR_GAIN    = 8'h03;
    localparam logic [7:0] ADDR_RATE    = 8'h04;
    localparam logic [7:0] ADDR_REFCTL  = 8'h05;
    localparam logic [7:0] ADDR_IDAC1   = 8'h06;

    // Status flag positions
    localparam int ST_POS_HI   = 5;
    localparam int ST_POS_LO   = 4;
    localparam int ST_NEG_HI   = 3;
    localparam int ST_NEG_LO   = 2;
    localparam int ST_REF1_LOW = 1;
    localparam int ST_REF0_LOW = 0;

    // Field positions
    localparam int GAIN_AMP_LO   = 3;
    localparam int RATE_CLK_BIT  = 6;
    localparam int REF_PBUF_BIT  = 5;
    localparam int REF_NBUF_BIT  = 4;
    localparam int REF_SEL_LO    = 2;
    localparam int REF_CON_LO    = 0;
    localparam int IDAC1_RAIL_EN = 7;

    // Field encodings
    localparam logic [1:0] AMP_OFF     = 2'h0;
    localparam logic [1:0] AMP_ON      = 2'h1;
    localparam logic [1:0] REFSEL_EXT0 = 2'h0;
    localparam logic [1:0] REFSEL_EXT1 = 2'h1;
    localparam logic [1:0] REFSEL_INT  = 2'h2;
    localparam logic [1:0] REFCON_OFF  = 2'h0;
    localparam logic [1:0] REFCON_PD   = 2'h1;
    localparam logic [1:0] REFCON_ON   = 2'h2;

    // Reset values
    localparam logic [7:0] GAIN_RST   = 8'h08;
    localparam logic [7:0] RATE_RST   = 8'h14;
    localparam logic [7:0] REFCTL_RST = 8'h30;
    localparam logic [7:0] IDAC1_RST  = 8'h00;

    // Analog threshold of the rail comparators, informative only
    localparam int RAIL_MARGIN_MV = 150;

    // Clock source switch sequence
    typedef enum logic [1:0] {
        ARC_SW_RUN   = 2'h0,
        ARC_SW_DRAIN = 2'h1,
        ARC_SW_WAIT  = 2'h3
    } arc_sw_e;

endpackage

// ### inc/arc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arc_clk_if;
    logic want_ext;
    logic sys_tick;
    logic ext_active;
    logic switching;
    modport sel (input want_ext, output sys_tick, output ext_active, output switching);
    modport ctl (output want_ext, input sys_tick, input ext_active, input switching);
endinterface
`default_nettype wire

// ### verilog/arc_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module arc_clk_sel
    import arc_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic ext_clk_in,
    input  wire logic osc_tick_in,
    arc_clk_if.sel    cif
);

    typedef struct packed {
        logic    ext_meta;
        logic    ext_sync;
        logic    ext_last;
        logic    osc_meta;
        logic    osc_sync;
        logic    osc_last;
        logic    cur_ext;
        arc_sw_e phase;
        logic    tick;
    } arc_sel_s;

    localparam arc_sel_s SEL_RST = '{default: '0, phase: ARC_SW_RUN};

    arc_sel_s sel_ff;
    arc_sel_s nxt_sel;
    logic     ext_edge;
    logic     osc_edge;
    logic     old_edge;
    logic     new_edge;

    assign ext_edge = sel_ff.ext_sync & ~sel_ff.ext_last;
    assign osc_edge = sel_ff.osc_sync & ~sel_ff.osc_last;
    assign old_edge = sel_ff.cur_ext ? ext_edge : osc_edge;
    assign new_edge = cif.want_ext ? ext_edge : osc_edge;

    // Switching parks the tick stream between whole periods of both sources
    always_comb
    begin
        nxt_sel          = sel_ff;
        nxt_sel.ext_meta = ext_clk_in;
        nxt_sel.ext_sync = sel_ff.ext_meta;
        nxt_sel.ext_last = sel_ff.ext_sync;
        nxt_sel.osc_meta = osc_tick_in;
        nxt_sel.osc_sync = sel_ff.osc_meta;
        nxt_sel.osc_last = sel_ff.osc_sync;
        nxt_sel.tick     = 1'b0;
        case (sel_ff.phase)
            ARC_SW_RUN:
            begin
                nxt_sel.tick = old_edge;
                if (cif.want_ext != sel_ff.cur_ext)
                begin
                    nxt_sel.phase = ARC_SW_DRAIN;
                end
            end
            ARC_SW_DRAIN:
            begin
                if (old_edge)
                begin
                    nxt_sel.cur_ext = cif.want_ext;
                    nxt_sel.phase   = ARC_SW_WAIT;
                end
            end
            ARC_SW_WAIT:
            begin
                if (new_edge)
                begin
                    nxt_sel.cur_ext = cif.want_ext;
                    nxt_sel.phase   = ARC_SW_RUN;
                end
            end
            default:
            begin
                nxt_sel.phase = ARC_SW_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sel_ff <= SEL_RST;
        end
        else
        begin
            sel_ff <= nxt_sel;
        end
    end

    assign cif.sys_tick   = sel_ff.tick;
    assign cif.ext_active = sel_ff.cur_ext;
    assign cif.switching  = (sel_ff.phase != ARC_SW_RUN);

    property p_no_tick_switch;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (sel_ff.phase != ARC_SW_RUN) |=> !sel_ff.tick;
    endproperty
    a_no_tick_switch: assert property (p_no_tick_switch) else $error("tick during clock switch");

    property p_src_follow;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (sel_ff.phase == ARC_SW_RUN && cif.want_ext == sel_ff.cur_ext && old_edge) |=> sel_ff.tick;
    endproperty
    a_src_follow: assert property (p_src_follow) else $error("selected source edge gave no tick");

endmodule
`default_nettype wire

// ### verilog/arc_top.sv
// Operation
// - Four PGA output rail flags near rails
// - Rail flags only while detect enabled
// - Amp field 00 powers down and bypasses
// - Reference select; first external pair after reset
// - Select value 10 picks internal reference
// - Reference power: 10 always, 01 sleeps
// - Internal reference off after reset
// - Reference buffer bits are active low
// - Per-pair low reference flags during conversion
// - Clock bit selects oscillator or external
// - Power-up selects the internal oscillator
// - Any reset returns to internal oscillator
// - Amp 01 enables; 10/11 never written
`timescale 1ns/1ps
`default_nettype none
module arc_top
    import arc_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       reset_cmd_in,
    input  wire logic       ext_clk_in,
    input  wire logic       osc_tick_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] rd_addr_in,
    output logic      [7:0] rd_data_out,
    input  wire logic       pos_out_high_cmp_in,
    input  wire logic       pos_out_low_cmp_in,
    input  wire logic       neg_out_high_cmp_in,
    input  wire logic       neg_out_low_cmp_in,
    input  wire logic       ref_pair1_low_cmp_in,
    input  wire logic       ref_pair0_low_cmp_in,
    input  wire logic       conv_active_in,
    input  wire logic       power_down_in,
    output logic            amp_power_out,
    output logic            amp_bypass_out,
    output logic      [1:0] ref_select_out,
    output logic            int_ref_on_out,
    output logic            pos_ref_buf_en_out,
    output logic            neg_ref_buf_en_out,
    output logic            sys_tick_out,
    output logic            clk_ext_active_out,
    output logic            clk_switching_out
);

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] rate;
        logic [7:0] refctl;
        logic [7:0] idac1;
        logic [5:0] cmp_meta;
        logic [5:0] cmp_sync;
        logic [5:0] flags;
        logic [7:0] rd_data;
    } arc_top_s;

    localparam arc_top_s TOP_RST = '{
        gain:     GAIN_RST,
        rate:     RATE_RST,
        refctl:   REFCTL_RST,
        idac1:    IDAC1_RST,
        cmp_meta: 6'h00,
        cmp_sync: 6'h00,
        flags:    6'h00,
        rd_data:  8'h00
    };

    arc_top_s   st_ff;
    arc_top_s   nxt_st;
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    logic [5:0] cmp_pins;
    logic       rail_en;
    logic [1:0] amp_field;
    logic [1:0] ref_sel;
    logic [1:0] ref_con;
    logic [7:0] status_byte;

    arc_clk_if cif ();

    // Reset is held until two clock edges after the pin releases
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    arc_clk_sel u_clk_sel (
        .clk_sys_in  (clk_sys_in),
        .rst_n_in    (rst_n),
        .ext_clk_in  (ext_clk_in),
        .osc_tick_in (osc_tick_in),
        .cif         (cif)
    );

    assign cmp_pins = {pos_out_high_cmp_in, pos_out_low_cmp_in, neg_out_high_cmp_in,
                       neg_out_low_cmp_in, ref_pair1_low_cmp_in, ref_pair0_low_cmp_in};

    assign rail_en     = st_ff.idac1[IDAC1_RAIL_EN];
    assign amp_field   = st_ff.gain[GAIN_AMP_LO +: 2];
    assign ref_sel     = st_ff.refctl[REF_SEL_LO +: 2];
    assign ref_con     = st_ff.refctl[REF_CON_LO +: 2];
    assign status_byte = {2'h0, st_ff.flags};

    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.cmp_meta = cmp_pins;
        nxt_st.cmp_sync = st_ff.cmp_meta;
        // Comparators already carry the rail margin; logic only qualifies them
        nxt_st.flags[ST_POS_HI:ST_NEG_LO] = rail_en ? st_ff.cmp_sync[ST_POS_HI:ST_NEG_LO] : 4'h0;
        // Reference monitor only samples while a conversion is running
        if (conv_active_in && cif.sys_tick)
        begin
            nxt_st.flags[ST_REF1_LOW:ST_REF0_LOW] = st_ff.cmp_sync[ST_REF1_LOW:ST_REF0_LOW];
        end
        if (wr_en_in)
        begin
            case (wr_addr_in)
                ADDR_GAIN:
                begin
                    nxt_st.gain = wr_data_in;
                    // Reserved amp codes would leave the front end undefined, keep old field
                    if (wr_data_in[GAIN_AMP_LO +: 2] != AMP_OFF && wr_data_in[GAIN_AMP_LO +: 2] != AMP_ON)
                    begin
                        nxt_st.gain[GAIN_AMP_LO +: 2] = amp_field;
                    end
                end
                ADDR_RATE:   nxt_st.rate   = wr_data_in;
                ADDR_REFCTL: nxt_st.refctl = wr_data_in;
                ADDR_IDAC1:  nxt_st.idac1  = wr_data_in;
                default:     nxt_st.gain   = st_ff.gain;
            endcase
        end
        if (reset_cmd_in)
        begin
            nxt_st.gain   = GAIN_RST;
            nxt_st.rate   = RATE_RST;
            nxt_st.refctl = REFCTL_RST;
            nxt_st.idac1  = IDAC1_RST;
            nxt_st.flags  = 6'h00;
        end
        case (rd_addr_in)
            ADDR_STATUS: nxt_st.rd_data = status_byte;
            ADDR_GAIN:   nxt_st.rd_data = st_ff.gain;
            ADDR_RATE:   nxt_st.rd_data = st_ff.rate;
            ADDR_REFCTL: nxt_st.rd_data = st_ff.refctl;
            ADDR_IDAC1:  nxt_st.rd_data = st_ff.idac1;
            default:     nxt_st.rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= TOP_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cif.want_ext       = st_ff.rate[RATE_CLK_BIT];
    assign amp_power_out      = (amp_field == AMP_ON);
    assign amp_bypass_out     = (amp_field == AMP_OFF);
    assign ref_select_out     = ref_sel;
    assign int_ref_on_out     = (ref_con == REFCON_ON) || (ref_con == REFCON_PD && !power_down_in);
    assign pos_ref_buf_en_out = ~st_ff.refctl[REF_PBUF_BIT];
    assign neg_ref_buf_en_out = ~st_ff.refctl[REF_NBUF_BIT];
    assign rd_data_out        = st_ff.rd_data;
    assign sys_tick_out       = cif.sys_tick;
    assign clk_ext_active_out = cif.ext_active;
    assign clk_switching_out  = cif.switching;

    property p_rail_set;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rail_en && st_ff.cmp_sync[ST_POS_HI] && !reset_cmd_in) |=> st_ff.flags[ST_POS_HI];
    endproperty
    a_rail_set: assert property (p_rail_set) else $error("rail flag not raised");

    property p_rail_off;
        @(posedge clk_sys_in) disable iff (!rst_n)
        !rail_en |=> (st_ff.flags[ST_POS_HI:ST_NEG_LO] == 4'h0);
    endproperty
    a_rail_off: assert property (p_rail_off) else $error("rail flag while detect disabled");

    property p_bypass;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (amp_field == AMP_OFF) |-> (amp_bypass_out && !amp_power_out);
    endproperty
    a_bypass: assert property (p_bypass) else $error("amp off without bypass");

    property p_reserved;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (wr_en_in && wr_addr_in == ADDR_GAIN && wr_data_in[GAIN_AMP_LO +: 2] > AMP_ON && !reset_cmd_in)
        |=> $stable(amp_field);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved amp code stored");

    property p_int_ref_sel;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (wr_en_in && wr_addr_in == ADDR_REFCTL && wr_data_in[REF_SEL_LO +: 2] == REFSEL_INT && !reset_cmd_in)
        |=> (ref_select_out == REFSEL_INT);
    endproperty
    a_int_ref_sel: assert property (p_int_ref_sel) else $error("internal reference not selected");

    property p_refcon;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (ref_con == REFCON_PD) |-> (int_ref_on_out == !power_down_in);
    endproperty
    a_refcon: assert property (p_refcon) else $error("reference power mode wrong");

    property p_reset_cmd;
        @(posedge clk_sys_in) disable iff (!rst_n)
        reset_cmd_in |=> (!cif.want_ext && ref_con == REFCON_OFF && ref_sel == REFSEL_EXT0);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left config");

    property p_buf_low;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (wr_en_in && wr_addr_in == ADDR_REFCTL && wr_data_in[REF_PBUF_BIT] && !reset_cmd_in)
        |=> !pos_ref_buf_en_out;
    endproperty
    a_buf_low: assert property (p_buf_low) else $error("buffer enabled by a one");

    property p_ref_mon;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (conv_active_in && cif.sys_tick && st_ff.cmp_sync[ST_REF0_LOW] && !reset_cmd_in)
        |=> st_ff.flags[ST_REF0_LOW];
    endproperty
    a_ref_mon: assert property (p_ref_mon) else $error("reference low flag missed");

endmodule
`default_nettype wire

// ### verif/arc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module arc_host_model
    import arc_pkg::*;
#(
    parameter int SETTLE_CYCLES = 40
)
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    output logic            wr_en_out,
    output logic      [7:0] wr_addr_out,
    output logic      [7:0] wr_data_out,
    output logic      [7:0] rd_addr_out
);
    logic excitation_current_source_used = 1'b0;
    initial
    begin
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        rd_addr_out = 8'h00;
    end
    // Raw writes skip the host's own care and exist only to probe refusals
    task wr(input logic [7:0] a, input logic [7:0] d, input bit raw, output logic [7:0] sent);
        sent = d;
        if (!raw && a == ADDR_GAIN)
        begin
            sent[4] = 1'b0;
            if (sent[4:3] == AMP_OFF)
                sent[2:0] = 3'h0;
        end
        if (a == ADDR_IDAC1)
            excitation_current_source_used = sent[6:0] != 7'h00;
        if (!raw && a == ADDR_REFCTL)
        begin
            if (sent[3:2] == 2'h3)
                sent[3:2] = REFSEL_INT;
            if (sent[1:0] == 2'h3 || (excitation_current_source_used && sent[1:0] == REFCON_OFF))
                sent[1:0] = REFCON_ON;
            if (sent[3:2] == REFSEL_INT)
                sent[5:4] = 2'h3;
        end
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        wr_addr_out <= a;
        wr_data_out <= sent;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~sent;
        // Settling shortened; a real reference needs milliseconds
        if (a == ADDR_REFCTL && sent[1:0] != REFCON_OFF)
            repeat (SETTLE_CYCLES) @(posedge clk_in);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_addr_out <= a;
        @(posedge clk_in);
        #1;
        d = rd_data_in;
    endtask
endmodule
`default_nettype wire

// ### verif/arc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module arc_top_test;
    import arc_pkg::*;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       reset_cmd = 1'b0;
    logic       ext_clk = 1'b0;
    logic       osc_tick = 1'b0;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [3:0] rail_cmp = 4'h0;
    logic [1:0] refl_cmp = 2'h0;
    logic       conv_active = 1'b0;
    logic       power_down = 1'b0;
    logic       amp_power;
    logic       amp_bypass;
    logic [1:0] ref_select;
    logic       int_ref_on;
    logic       pbuf_en;
    logic       nbuf_en;
    logic       sys_tick;
    logic       ext_active;
    logic       switching;
    logic [7:0] m_gain;
    logic [7:0] m_rate;
    logic [7:0] m_ref;
    logic [7:0] m_excitation_current_source;
    logic [7:0] v;
    logic [3:0] r;
    logic [1:0] q;
    logic [7:0] tab [6] = '{8'h01, ADDR_GAIN, ADDR_RATE, ADDR_REFCTL, ADDR_IDAC1, 8'h07};
    integer     seed = 32'h2CAE2B05;
    int         n_errors = 0;
    int         n_tests = 0;
    int         cycles = 0;
    int         cnt;

    always #12.5 clk = ~clk;
    // The oscillator period shares no factor with the system clock; the external period is six clocks
    always #122 osc_tick = ~osc_tick;
    always #75 ext_clk = ~ext_clk;

    arc_top u_arc_top (
        .clk_sys_in(clk), .resetn_in(resetn), .reset_cmd_in(reset_cmd), .ext_clk_in(ext_clk),
        .osc_tick_in(osc_tick), .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data), .pos_out_high_cmp_in(rail_cmp[3]),
        .pos_out_low_cmp_in(rail_cmp[2]), .neg_out_high_cmp_in(rail_cmp[1]), .neg_out_low_cmp_in(rail_cmp[0]),
        .ref_pair1_low_cmp_in(refl_cmp[1]), .ref_pair0_low_cmp_in(refl_cmp[0]), .conv_active_in(conv_active),
        .power_down_in(power_down), .amp_power_out(amp_power), .amp_bypass_out(amp_bypass),
        .ref_select_out(ref_select), .int_ref_on_out(int_ref_on), .pos_ref_buf_en_out(pbuf_en),
        .neg_ref_buf_en_out(nbuf_en), .sys_tick_out(sys_tick), .clk_ext_active_out(ext_active),
        .clk_switching_out(switching)
    );
    arc_host_model #(.SETTLE_CYCLES(40)) u_arc_host_model (
        .clk_in(clk), .rd_data_in(rd_data), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .rd_addr_out(rd_addr)
    );

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        $display("mismatches %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task m_reset;
        m_gain = GAIN_RST;
        m_rate = RATE_RST;
        m_ref = REFCTL_RST;
        m_excitation_current_source = IDAC1_RST;
    endtask
    task check_outs;
        check("amp_power", 8'(amp_power), 8'(m_gain[GAIN_AMP_LO+:2] == AMP_ON));
        check("amp_bypass", 8'(amp_bypass), 8'(m_gain[GAIN_AMP_LO+:2] == AMP_OFF));
        check("ref_select", 8'(ref_select), 8'(m_ref[REF_SEL_LO+:2]));
        check("int_ref_on", 8'(int_ref_on), 8'(m_ref[1:0] == REFCON_ON || (m_ref[1:0] == REFCON_PD && !power_down)));
        check("buf_en", {6'h0, pbuf_en, nbuf_en}, {6'h0, ~m_ref[5:4]});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        u_arc_host_model.rd(a, v);
        check("rd_data", v, exp);
    endtask
    task check_regs;
        rd(ADDR_GAIN, m_gain);
        rd(ADDR_RATE, m_rate);
        rd(ADDR_REFCTL, m_ref);
        rd(ADDR_IDAC1, m_excitation_current_source);
        rd(8'h02, 8'h00);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
        u_arc_host_model.wr(a, d, raw, v);
        case (a)
            ADDR_GAIN: m_gain = v[4] ? {v[7:5], m_gain[4:3], v[2:0]} : v;
            ADDR_RATE: m_rate = v;
            ADDR_REFCTL: m_ref = v;
            ADDR_IDAC1: m_excitation_current_source = v;
            default: ;
        endcase
        #1;
        check_outs;
    endtask
    task do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        m_reset;
        #1;
        check("ext_active", 8'(ext_active), 8'h00);
        check_outs;
        check_regs;
    endtask
    task wait_clk(input logic want);
        // Sample the selector after its flops have settled, not in the edge's own time step
        for (int i = 0; i < 200 && (switching !== 1'b0 || ext_active !== want); i++)
        begin
            @(posedge clk);
            #1;
        end
        check("ext_active", 8'(ext_active), 8'(want));
    endtask
    task count_ticks(input int lo, input int hi);
        cnt = 0;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            #1;
            cnt += int'(sys_tick);
        end
        check("tick_count", 8'(cnt >= lo && cnt <= hi), 8'h01);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            final_report;
        end
    end

    initial
    begin
        do_reset;
        for (int k = 0; k < 48; k++)
        begin
            @(posedge clk);
            power_down <= 1'($random(seed));
            wr(tab[$unsigned($random(seed)) % 6], 8'($random(seed)), 1'b0);
            if (k % 8 == 7)
                check_regs;
        end
        wr(ADDR_IDAC1, 8'h00, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            power_down <= i[0];
            wr(ADDR_REFCTL, {4'h0, 2'(i / 3), 2'(i % 3)}, 1'b0);
        end
        wr(ADDR_GAIN, 8'h0A, 1'b0);
        wr(ADDR_GAIN, 8'h17, 1'b1);
        wr(ADDR_GAIN, 8'h1F, 1'b1);
        wr(ADDR_GAIN, 8'h00, 1'b0);
        rd(ADDR_GAIN, m_gain);
        // 400 cycles span 10 us: about 41 oscillator and 66 external edges
        wr(ADDR_RATE, RATE_RST, 1'b0);
        wait_clk(1'b0);
        count_ticks(40, 42);
        wr(ADDR_RATE, RATE_RST | 8'h40, 1'b0);
        wait_clk(1'b1);
        count_ticks(65, 68);
        @(posedge clk);
        reset_cmd <= 1'b1;
        @(posedge clk);
        reset_cmd <= 1'b0;
        m_reset;
        wait_clk(1'b0);
        check_outs;
        check_regs;
        wr(ADDR_RATE, 8'h54, 1'b0);
        wait_clk(1'b1);
        do_reset;
        wr(ADDR_IDAC1, 8'h80, 1'b0);
        r = 4'($random(seed));
        q = 2'($random(seed));
        @(posedge clk);
        rail_cmp <= r;
        refl_cmp <= q;
        // No conversion yet, so the reference flags still hold their cleared value
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, {2'h0, r, 2'h0});
        @(posedge clk);
        conv_active <= 1'b1;
        repeat (60) @(posedge clk);
        conv_active <= 1'b0;
        refl_cmp <= ~q;
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, {2'h0, r, q});
        wr(ADDR_IDAC1, 8'h00, 1'b0);
        rd(ADDR_STATUS, {6'h0, q});
        final_report;
    end
endmodule
`default_nettype wire
